//--- common/arc_defines.svh
/*
 * Offsets, field positions and reset values of the audio rate converter
 * routing bank. Assumes the includer maps index N to byte address 4*N.
 */
`ifndef ARC_DEFINES_SVH
`define ARC_DEFINES_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ARC_IDX_CONV4_THR 12'h907
`define ARC_IDX_CONV5_INC_LOW 12'h908
`define ARC_IDX_CONV5_INC_MID 12'h909
`define ARC_IDX_CONV5_INC_HIGH 12'h90a
`define ARC_IDX_CONV5_THR 12'h90b
`define ARC_IDX_CONV6_INC_LOW 12'h90c
`define ARC_IDX_CONV6_INC_MID 12'h90d
`define ARC_IDX_CONV6_INC_HIGH 12'h90e
`define ARC_IDX_CONV6_THR 12'h90f
`define ARC_IDX_ROUTE 12'h920
`define ARC_IDX_BYPASS 12'h921
`define ARC_IDX_STROBE_SEL 12'h922
`define ARC_IDX_STATUS 12'h923

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ARC_RST_THR 4'h8
`define ARC_RST_CONV5_LOW 8'h53
`define ARC_RST_CONV5_MID 8'h04
`define ARC_RST_CONV5_HIGH 2'h1
`define ARC_RST_CONV6_LOW 8'haa
`define ARC_RST_CONV6_MID 8'h4f
`define ARC_RST_CONV6_HIGH 2'h1
`define ARC_RST_ROUTE 8'hc9
`define ARC_RST_BYPASS 8'h00
`define ARC_RST_STROBE_SEL 6'h1b

// ----------------------------------------------------------------
// widths and bus answers
// ----------------------------------------------------------------
`define ARC_ADDR_W 16
`define ARC_LVL_W 5
`define ARC_RESP_OKAY 2'h0
`define ARC_RESP_SLVERR 2'h2

`endif

//--- common/arc_pkg.sv
/*
 * Types of the audio rate converter routing bank.
 * Assumes arc_defines.svh supplies the numbers.
 */
package arc_pkg;

    // converter picked by a destination selector
    typedef enum logic [1:0] {
        ARC_CONV3,
        ARC_CONV4,
        ARC_CONV5,
        ARC_CONV6
    } arc_conv_e;

    // source of a converter's output fifo read strobe
    typedef enum logic [1:0] {
        ARC_STB_WORD_SELECT,
        ARC_STB_CODEC_READ,
        ARC_STB_NICAM_ENABLE,
        ARC_STB_OWN_WRITE
    } arc_strobe_e;

    // routing register layout, msb first
    typedef struct packed {
        arc_conv_e codec_link_route;
        arc_conv_e serial_port_route;
        arc_conv_e second_parallel_route;
        arc_conv_e first_parallel_route;
    } arc_route_s;

    // one stereo sample word
    typedef struct packed {
        logic [15:0] left;
        logic [15:0] right;
    } arc_sample_s;

    // 18-bit phase increment built from three fields
    typedef struct packed {
        logic [1:0] high;
        logic [7:0] mid;
        logic [7:0] low;
    } arc_inc_s;

endpackage : arc_pkg

//--- rtl/arc_routing_bank.sv
/*
 * Configuration bank and routing of the later sample rate converters:
 * phase increments, read thresholds, output routing, baseband bypass.
 * Assumes an AXI4-Lite master on clk, converter streams on clk, and the
 * word select, codec read and nicam enable strobes arriving from pins.
 */
// Summary of operation
// - each converter increment is 18 bits, a low byte, a middle byte and a 2-bit top field.
// - one increment per converter serves both left and right channels.
// - the middle byte sits at bits 15 to 8 of the increment.
// - converter five resets to low 0x53, middle 0x04, top 01.
// - converter six resets to low 0xaa, middle 0x4f, top 01.
// - a 4-bit fill threshold, reset eight, gates the read enable of both channel fifos.
// - four destinations each own a 2-bit selector at bits 7:6, 5:4, 3:2 and 1:0.
// - selector values 0 to 3 route converters three to six.
// - routing resets to codec six, serial three, parallel two five, parallel one four.
// - each of eight bypass bits is independent, one bypasses, all reset to zero.
// - bypass bits 7 to 4 skip path two soft-clip, volume, equalizer and level control.
// - bypass bits 3 to 0 skip path one soft-clip, volume, equalizer and level control.
// - each converter read strobe comes from word select, codec read, nicam enable or own write.
`timescale 1ns/1ps
`include "arc_defines.svh"

module arc_routing_bank (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`ARC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`ARC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic word_select_pin,
    input wire logic codec_read_pin,
    input wire logic nicam_enable_pin,
    input wire logic [2:0] conv_fifo_write,
    input wire logic [2:0][`ARC_LVL_W-1:0] conv_fifo_level,
    output logic [2:0] conv_read_enable,
    output arc_pkg::arc_inc_s conv5_increment,
    output arc_pkg::arc_inc_s conv6_increment,
    output logic [2:0][3:0] conv_read_threshold,
    output logic [7:0] baseband_stage_bypass,
    input wire arc_pkg::arc_sample_s [3:0] conv_sample,
    input wire logic [3:0] conv_valid,
    output arc_pkg::arc_sample_s codec_link_sample,
    output logic codec_link_valid,
    output arc_pkg::arc_sample_s first_parallel_sample,
    output logic first_parallel_valid,
    output arc_pkg::arc_sample_s second_parallel_sample,
    output logic second_parallel_valid,
    output arc_pkg::arc_sample_s serial_port_sample,
    output logic serial_port_valid,
    input wire logic serial_port_ready,
    output logic serial_source_ready
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    // true for every index that the bank answers with okay
    function automatic logic idx_mapped(input logic [11:0] idx);
        idx_mapped = (idx >= `ARC_IDX_CONV4_THR && idx <= `ARC_IDX_CONV6_THR) ||
                     (idx >= `ARC_IDX_ROUTE && idx <= `ARC_IDX_STATUS);
    endfunction : idx_mapped

    function automatic arc_pkg::arc_sample_s route_pick(input arc_pkg::arc_conv_e sel,
                                                         input arc_pkg::arc_sample_s [3:0] smp);
        route_pick = smp[sel];
    endfunction : route_pick

    function automatic logic strobe_pick(input logic [1:0] sel, input logic [2:0] ext, input logic own);
        case (arc_pkg::arc_strobe_e'(sel))
            arc_pkg::ARC_STB_WORD_SELECT: strobe_pick = ext[0];
            arc_pkg::ARC_STB_CODEC_READ: strobe_pick = ext[1];
            arc_pkg::ARC_STB_NICAM_ENABLE: strobe_pick = ext[2];
            arc_pkg::ARC_STB_OWN_WRITE: strobe_pick = own;
            default: strobe_pick = 1'b0;
        endcase
    endfunction : strobe_pick

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic aw_got_ff, w_got_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic [11:0] waddr_idx_ff;
    logic [7:0] wbyte_ff;
    logic wlane_ff;
    logic aw_hs, w_hs, do_write, ar_hs;
    logic [11:0] raddr_idx;
    logic [2:0][3:0] thr_ff;
    arc_pkg::arc_inc_s inc5_ff, inc6_ff;
    arc_pkg::arc_route_s route_ff;
    logic [7:0] bypass_ff;
    logic [5:0] strobe_sel_ff;
    logic [2:0] sync1_ff, sync2_ff, sync3_ff, filt_ff, filt_prev_ff;
    logic [2:0] ext_event;
    logic [2:0] rd_en_ff;
    arc_pkg::arc_sample_s codec_ff, par1_ff, par2_ff, head_ff, spare_ff;
    logic codec_v_ff, par1_v_ff, par2_v_ff;
    logic [1:0] cnt_ff, nxt_cnt;
    logic out_v_ff, in_rdy_ff;
    logic push, pop, in_valid;
    arc_pkg::arc_sample_s in_sample;

    // ----------------------------------------------------------------
    // axi write channel
    // ----------------------------------------------------------------
    assign aw_hs = s_axi_awvalid && awready_ff;
    assign w_hs = s_axi_wvalid && wready_ff;
    assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;

    // address and data are taken in either order, held until both are in
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_got_ff <= 1'b0;
            waddr_idx_ff <= 12'h000;
        end else if (aw_hs) begin
            aw_got_ff <= 1'b1;
            waddr_idx_ff <= s_axi_awaddr[13:2];
        end else if (do_write) begin
            aw_got_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_got_ff <= 1'b0;
            wbyte_ff <= 8'h00;
            wlane_ff <= 1'b0;
        end else if (w_hs) begin
            w_got_ff <= 1'b1;
            wbyte_ff <= s_axi_wdata[7:0];
            wlane_ff <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_got_ff <= 1'b0;
        end
    end

    // ready drops after a take and returns once the response is gone
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
        end else begin
            awready_ff <= aw_hs ? 1'b0 : (!aw_got_ff && !bvalid_ff);
            wready_ff <= w_hs ? 1'b0 : (!w_got_ff && !bvalid_ff);
        end
    end

    // unmapped writes are dropped and answered with slverr
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `ARC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= idx_mapped(waddr_idx_ff) ? `ARC_RESP_OKAY : `ARC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    // only byte lane 0 carries data; reserved bits are never stored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            thr_ff <= {3{`ARC_RST_THR}};
            inc5_ff <= {`ARC_RST_CONV5_HIGH, `ARC_RST_CONV5_MID, `ARC_RST_CONV5_LOW};
            inc6_ff <= {`ARC_RST_CONV6_HIGH, `ARC_RST_CONV6_MID, `ARC_RST_CONV6_LOW};
            route_ff <= `ARC_RST_ROUTE;
            bypass_ff <= `ARC_RST_BYPASS;
            strobe_sel_ff <= `ARC_RST_STROBE_SEL;
        end else if (do_write && wlane_ff) begin
            case (waddr_idx_ff)
                `ARC_IDX_CONV4_THR: thr_ff[0] <= wbyte_ff[3:0];
                `ARC_IDX_CONV5_INC_LOW: inc5_ff.low <= wbyte_ff;
                `ARC_IDX_CONV5_INC_MID: inc5_ff.mid <= wbyte_ff;
                `ARC_IDX_CONV5_INC_HIGH: inc5_ff.high <= wbyte_ff[1:0];
                `ARC_IDX_CONV5_THR: thr_ff[1] <= wbyte_ff[3:0];
                `ARC_IDX_CONV6_INC_LOW: inc6_ff.low <= wbyte_ff;
                `ARC_IDX_CONV6_INC_MID: inc6_ff.mid <= wbyte_ff;
                `ARC_IDX_CONV6_INC_HIGH: inc6_ff.high <= wbyte_ff[1:0];
                `ARC_IDX_CONV6_THR: thr_ff[2] <= wbyte_ff[3:0];
                `ARC_IDX_ROUTE: route_ff <= wbyte_ff;
                `ARC_IDX_BYPASS: bypass_ff <= wbyte_ff;
                `ARC_IDX_STROBE_SEL: strobe_sel_ff <= wbyte_ff[5:0];
                default: ;
            endcase
        end
    end

    // one increment per converter feeds both channel resamplers
    assign conv5_increment = inc5_ff;
    assign conv6_increment = inc6_ff;
    assign conv_read_threshold = thr_ff;
    // bits 7:4 steer path two stages, 3:0 path one, same order
    assign baseband_stage_bypass = bypass_ff;

    // ----------------------------------------------------------------
    // axi read channel
    // ----------------------------------------------------------------
    assign ar_hs = s_axi_arvalid && arready_ff;
    assign raddr_idx = s_axi_araddr[13:2];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arready_ff <= 1'b0;
        end else begin
            arready_ff <= ar_hs ? 1'b0 : !rvalid_ff;
        end
    end

    // reserved and unused bits read as zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `ARC_RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= idx_mapped(raddr_idx) ? `ARC_RESP_OKAY : `ARC_RESP_SLVERR;
            case (raddr_idx)
                `ARC_IDX_CONV4_THR: rdata_ff <= {28'h0, thr_ff[0]};
                `ARC_IDX_CONV5_INC_LOW: rdata_ff <= {24'h0, inc5_ff.low};
                `ARC_IDX_CONV5_INC_MID: rdata_ff <= {24'h0, inc5_ff.mid};
                `ARC_IDX_CONV5_INC_HIGH: rdata_ff <= {30'h0, inc5_ff.high};
                `ARC_IDX_CONV5_THR: rdata_ff <= {28'h0, thr_ff[1]};
                `ARC_IDX_CONV6_INC_LOW: rdata_ff <= {24'h0, inc6_ff.low};
                `ARC_IDX_CONV6_INC_MID: rdata_ff <= {24'h0, inc6_ff.mid};
                `ARC_IDX_CONV6_INC_HIGH: rdata_ff <= {30'h0, inc6_ff.high};
                `ARC_IDX_CONV6_THR: rdata_ff <= {28'h0, thr_ff[2]};
                `ARC_IDX_ROUTE: rdata_ff <= {24'h0, route_ff};
                `ARC_IDX_BYPASS: rdata_ff <= {24'h0, bypass_ff};
                `ARC_IDX_STROBE_SEL: rdata_ff <= {26'h0, strobe_sel_ff};
                `ARC_IDX_STATUS: rdata_ff <= {26'h0, cnt_ff, 1'b0, filt_ff};
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // external strobe synchronisers and read enables
    // ----------------------------------------------------------------
    // a bit changes only once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            sync3_ff <= 3'h0;
            filt_ff <= 3'h0;
            filt_prev_ff <= 3'h0;
        end else begin
            sync1_ff <= {nicam_enable_pin, codec_read_pin, word_select_pin};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            filt_ff <= (sync2_ff & sync3_ff) | (filt_ff & (sync2_ff | sync3_ff));
            filt_prev_ff <= filt_ff;
        end
    end

    assign ext_event = filt_ff & ~filt_prev_ff;

    // one enable pulse per strobe event while fill reaches the threshold
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_en_ff <= 3'h0;
        end else begin
            for (int k = 0; k < 3; k++) begin
                rd_en_ff[k] <= strobe_pick(strobe_sel_ff[2*k +: 2], ext_event, conv_fifo_write[k]) &&
                               (conv_fifo_level[k] >= {1'b0, thr_ff[k]});
            end
        end
    end

    assign conv_read_enable = rd_en_ff;

    // ----------------------------------------------------------------
    // unbuffered destinations
    // ----------------------------------------------------------------
    // these sinks never stall, so a plain register stage is enough
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            codec_ff <= '0;
            par1_ff <= '0;
            par2_ff <= '0;
            codec_v_ff <= 1'b0;
            par1_v_ff <= 1'b0;
            par2_v_ff <= 1'b0;
        end else begin
            codec_ff <= route_pick(route_ff.codec_link_route, conv_sample);
            codec_v_ff <= conv_valid[route_ff.codec_link_route];
            par1_ff <= route_pick(route_ff.first_parallel_route, conv_sample);
            par1_v_ff <= conv_valid[route_ff.first_parallel_route];
            par2_ff <= route_pick(route_ff.second_parallel_route, conv_sample);
            par2_v_ff <= conv_valid[route_ff.second_parallel_route];
        end
    end

    assign codec_link_sample = codec_ff;
    assign codec_link_valid = codec_v_ff;
    assign first_parallel_sample = par1_ff;
    assign first_parallel_valid = par1_v_ff;
    assign second_parallel_sample = par2_ff;
    assign second_parallel_valid = par2_v_ff;

    // ----------------------------------------------------------------
    // serial port two-entry buffer
    // ----------------------------------------------------------------
    assign in_sample = route_pick(route_ff.serial_port_route, conv_sample);
    assign in_valid = conv_valid[route_ff.serial_port_route];
    assign push = in_valid && in_rdy_ff;
    assign pop = out_v_ff && serial_port_ready;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 2'h1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 2'h1;
        end
    end

    // head is the output word, so data leaves straight from a flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            head_ff <= '0;
            spare_ff <= '0;
        end else if (pop) begin
            if (cnt_ff == 2'h2) begin
                head_ff <= spare_ff;
            end else if (push) begin
                head_ff <= in_sample;
            end
        end else if (push) begin
            if (cnt_ff == 2'h0) begin
                head_ff <= in_sample;
            end else begin
                spare_ff <= in_sample;
            end
        end
    end

    // ready is registered; the spare entry absorbs the word in flight
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 2'h0;
            out_v_ff <= 1'b0;
            in_rdy_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            out_v_ff <= (nxt_cnt != 2'h0);
            in_rdy_ff <= (nxt_cnt != 2'h2);
        end
    end

    assign serial_port_sample = head_ff;
    assign serial_port_valid = out_v_ff;
    assign serial_source_ready = in_rdy_ff;

    // ----------------------------------------------------------------
    // bus outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

endmodule : arc_routing_bank

//--- verif/arc_properties.sv
/*
 * Concurrent checks on the ports of the routing bank.
 * Assumes one clock domain.
 */
`timescale 1ns/1ps
`include "arc_defines.svh"

module arc_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire arc_pkg::arc_inc_s conv5_increment,
    input wire logic [7:0] baseband_stage_bypass,
    input wire logic [2:0][`ARC_LVL_W-1:0] conv_fifo_level,
    input wire logic [2:0][3:0] conv_read_threshold,
    input wire logic [2:0] conv_read_enable,
    input wire logic serial_port_valid,
    input wire logic serial_port_ready,
    input wire arc_pkg::arc_sample_s serial_port_sample
);
    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write answer late");
    aw_refused_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
        else $error("write address taken twice");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("reserved read bits set");
    // conv5 increment and bypass may only move with a write answer, so no stray stores
    inc_store_a: assert property (!$stable(conv5_increment) || !$stable(baseband_stage_bypass)
        |-> ##[0:1] s_axi_bvalid) else $error("config changed without a write");
    read_gate_a: assert property (conv_read_enable[0]
        |-> $past(conv_fifo_level[0]) >= $past(conv_read_threshold[0])) else $error("read enable below threshold");
    serial_hold_a: assert property (serial_port_valid && !serial_port_ready
        |=> serial_port_valid && $stable(serial_port_sample)) else $error("serial word lost in stall");
endmodule : arc_properties

//--- verif/tb.sv
/*
 * Self-checking bench of the routing bank.
 * Assumes the checker file is compiled.
 */
`timescale 1ns/1ps
`include "arc_defines.svh"

module tb;
    logic clk = 1'h0, rst_n = 1'h0;
    logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf, conv_valid = 4'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic word_select_pin = 1'h0, codec_read_pin = 1'h0, nicam_enable_pin = 1'h0, serial_port_ready = 1'h1;
    logic [2:0] conv_fifo_write = 3'h0, conv_read_enable;
    logic [2:0][`ARC_LVL_W-1:0] conv_fifo_level = 15'h0;
    arc_pkg::arc_inc_s conv5_increment, conv6_increment;
    logic [2:0][3:0] conv_read_threshold;
    logic [7:0] baseband_stage_bypass;
    arc_pkg::arc_sample_s [3:0] conv_sample = 128'h0;
    arc_pkg::arc_sample_s codec_link_sample, first_parallel_sample, second_parallel_sample, serial_port_sample;
    logic codec_link_valid, first_parallel_valid, second_parallel_valid, serial_port_valid, serial_source_ready;
    int error_cnt = 0, cmp_count = 0, n[3];
    // index, reset, written, read back
    localparam logic [35:0] ROWS [13] = '{{12'h907, 24'h08ff0f}, {12'h908, 24'h531212}, {12'h909, 24'h043434},
        {12'h90a, 24'h01ff03}, {12'h90b, 24'h080303}, {12'h90c, 24'haa5656}, {12'h90d, 24'h4f7878},
        {12'h90e, 24'h010202}, {12'h90f, 24'h080000}, {12'h920, 24'hc91b1b}, {12'h921, 24'h00a5a5},
        {12'h922, 24'h1bff3f}, {12'h923, 24'h00ff00}};

    always #12.5 clk = ~clk;
    arc_routing_bank dut_u (.*);

    task automatic check(input string nm, input logic [127:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out

    // address and data offered together, each dropped once taken
    task automatic axw(input logic [11:0] ix, input logic [7:0] v, input logic [3:0] st, output logic [1:0] r);
        int k;
        k = 0;
        @(posedge clk);
        s_axi_awaddr <= {2'h0, ix, 2'h0};
        s_axi_wdata <= {24'h0, v};
        s_axi_wstrb <= st;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clk);
            k++;
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1 && k < 50);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        if (s_axi_bvalid !== 1'h1) begin
            error_cnt++;
            close_out();
        end
    endtask : axw

    task automatic axr(input logic [11:0] ix, output logic [31:0] v, output logic [1:0] r);
        int k;
        k = 0;
        @(posedge clk);
        s_axi_araddr <= {2'h0, ix, 2'h0};
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge clk);
            k++;
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1 && k < 50);
        {v, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'h0;
        if (s_axi_rvalid !== 1'h1) begin
            error_cnt++;
            close_out();
        end
    endtask : axr

    // read enable pulses in ten cycles
    task automatic cnt_en();
        n = '{0, 0, 0};
        repeat (10) begin
            @(posedge clk);
            for (int k = 0; k < 3; k++) if (conv_read_enable[k] === 1'h1) n[k]++;
        end
    endtask : cnt_en

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        check("conv5_inc", 32'h10453, conv5_increment);
        check("conv6_inc", 32'h14faa, conv6_increment);
        check("threshold", 32'h888, conv_read_threshold);
        check("bypass", 32'h0, baseband_stage_bypass);
        foreach (ROWS[i]) begin
            axr(ROWS[i][35:24], d, rs);
            check("reset value", ROWS[i][23:16], d);
            axw(ROWS[i][35:24], ROWS[i][15:8], 4'hf, rs);
            axr(ROWS[i][35:24], d, rs);
            check("read back", ROWS[i][7:0], d);
        end
        check("conv5_inc", 32'h33412, conv5_increment);
        check("conv6_inc", 32'h27856, conv6_increment);
        check("threshold", 32'h03f, conv_read_threshold);
        // each converter carries its own number
        conv_sample <= {32'h60006000, 32'h50005000, 32'h40004000, 32'h30003000};
        conv_valid <= 4'hf;
        repeat (4) @(posedge clk);
        check("codec", 33'h130003000, {codec_link_valid, codec_link_sample});
        check("serial", 33'h140004000, {serial_port_valid, serial_port_sample});
        check("second", 33'h150005000, {second_parallel_valid, second_parallel_sample});
        check("first", 33'h160006000, {first_parallel_valid, first_parallel_sample});
        for (int v = 0; v < 4; v++) begin
            axw(12'h920, {4{v[1:0]}}, 4'hf, rs);
            repeat (5) @(posedge clk);
            d = (v + 3) * 32'h10001000;
            check("all routes", {4{d}}, {codec_link_sample, serial_port_sample,
                second_parallel_sample, first_parallel_sample});
        end
        // stall the serial sink until the buffer refuses
        serial_port_ready <= 1'h0;
        for (int k = 0; k < 20 && serial_source_ready !== 1'h0; k++) @(posedge clk);
        check("source ready", 32'h0, serial_source_ready);
        check("serial held", 32'h60006000, serial_port_sample);
        serial_port_ready <= 1'h1;
        axw(12'h921, 8'h00, 4'h0, rs);
        check("bypass no strobe", 32'ha5, baseband_stage_bypass);
        axw(12'h921, 8'h5a, 4'hf, rs);
        check("bypass", 32'h5a, baseband_stage_bypass);
        axw(12'h930, 8'h11, 4'hf, rs);
        check("unmapped bresp", 32'h2, rs);
        axr(12'h930, d, rs);
        check("unmapped read", 32'h2, {d, rs});
        // levels of converters four and five just below threshold, then just at it; six stays at its zero threshold
        for (int lv = 0; lv < 2; lv++) begin
            axw(12'h922, lv ? 8'h2c : 8'h1b, 4'hf, rs);
            conv_fifo_level <= {5'h0, 5'h2 + lv[4:0], 5'he + lv[4:0]};
            {codec_read_pin, nicam_enable_pin, word_select_pin} <= 3'h0;
            repeat (6) @(posedge clk);
            {codec_read_pin, nicam_enable_pin, word_select_pin, conv_fifo_write} <= 6'h3b;
            @(posedge clk);
            conv_fifo_write <= 3'h0;
            cnt_en();
            check("read enables", {lv[0], lv[0], 1'h1}, {n[0] == 1, n[1] == 1, n[2] == 1});
        end
        // second reset in mid-run
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        check("reset bypass", 32'h0, baseband_stage_bypass);
        check("reset inc", 32'h10453, conv5_increment);
        rst_n <= 1'h1;
        axr(12'h920, d, rs);
        check("route", 32'hc9, d);
        close_out();
    end
endmodule : tb

bind arc_routing_bank arc_properties chk_u (.*);
